// ---- hw/lvdiw_top.sv ----
// What this block does
// - enable bit powers detector circuits
// - three-bit code selects trip level
// - code zero routes external pin
// - read-only flag shows low voltage
// - bandgap on for detector, reset, bit
// - control resets zero, upper bits zero
// - sleep forces detector off
// - flag follows comparator, no hysteresis
// - irq flag set after fixed delay
// - rising irq flag wakes device
// - irq flag sticks until cleared
// - vector needs all enables, stack room
// - service clears global and group flag
// - return restores, irq return re-enables
// - entry pushes only program counter
// - low voltage sets grouped irq flag when source enabled
`timescale 1ns/100ps
`default_nettype none
`include "lvdiw_map.svh"
module lvdiw_top
   import lvdiw_pkg::*;
#(
   parameter int DELAY_CYC = `LVDIW_DELAY_CYC
) (
   input  wire logic        mclk,        // system clock, 125 MHz
   input  wire logic        resetn,      // async reset, active low
   input  wire logic        psel,        // apb select
   input  wire logic        penable,     // apb access phase
   input  wire logic        pwrite,      // apb direction
   input  wire logic [11:0] paddr,       // apb byte address
   input  wire logic [31:0] pwdata,      // apb write data
   output logic      [31:0] prdata,      // apb read data
   output logic             pready,      // apb ready
   output logic             pslverr,     // apb error
   input  wire logic        compOut,     // analog comparator, async
   input  wire logic        sleepMode,   // device in sleep
   input  wire logic        idleMode,    // device in idle
   input  wire logic        lvrEnable,   // low voltage reset enabled
   input  wire logic        stackFull,   // return stack full
   input  wire logic        serviceAck,  // cpu took the vector
   input  wire logic        retStrobe,   // return executed
   input  wire logic        retKind,     // 1 irq return, 0 plain
   output logic             detPower,    // detector power enable
   output logic             pinSelect,   // 1 compare external pin
   output logic [2:0]       thrLevel,    // threshold code to analog
   output logic             bandgapOn,   // bandgap enable
   output logic             vectorReq,   // request to vector
   output logic             wakeUp,      // wake pulse
   output logic             pushPc,      // push program counter
   output logic             popPc,       // pop program counter
   output logic             irq          // level interrupt
);
   // ********************
   // storage
   // ********************
   lvdiw_thr_t thr_q;
   logic       bgEn_q;
   logic       detEn_q;
   logic       globalEn_q;
   logic       srcEn_q;
   logic       grpEn_q;
   logic       srcFlag_q;
   logic       grpFlag_q;
   logic       srcFlagDly_q;
   logic [`LVDIW_ST_W-1:0] status_q;
   logic [`LVDIW_ST_W-1:0] mask_q;
   logic       lvSync;
   logic       delayFire;
   logic       lvFlag;
   logic       wr;
   logic       rd;
   logic       mapped;
   logic       vectorTake;
   logic       wakeEdge;
   logic [31:0] rdMux;

   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && !penable && !pwrite;

   always_comb begin
      mapped = 1'b1;
      case (paddr)
         `LVDIW_OFS_CTRL,
         `LVDIW_OFS_IRQCTL,
         `LVDIW_OFS_STATUS,
         `LVDIW_OFS_MASK,
         `LVDIW_OFS_RETURN: mapped = 1'b1;
         default:           mapped = 1'b0;
      endcase
   end

   // ********************
   // comparator path
   // ********************
   lvdiw_sync u_sync (
      .mclk    (mclk),
      .resetn  (resetn),
      .asyncIn (compOut),
      .syncOut (lvSync)
   );

   // flag is the synchronised compare while powered, filtered until stages two and three agree
   assign lvFlag = lvSync && detEn_q && !sleepMode;

   lvdiw_delay #(
      .DELAY (DELAY_CYC)
   ) u_delay (
      .mclk   (mclk),
      .resetn (resetn),
      .level  (lvFlag),
      .fire   (delayFire)
   );

   // ********************
   // control register
   // ********************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         thr_q   <= 3'h0;
         bgEn_q  <= 1'b0;
         detEn_q <= 1'b0;
      end else if (wr && paddr == `LVDIW_OFS_CTRL) begin
         thr_q   <= pwdata[`LVDIW_CTRL_THR_LSB +: 3];
         bgEn_q  <= pwdata[`LVDIW_CTRL_BGEN];
         detEn_q <= pwdata[`LVDIW_CTRL_EN];
      end
   end

   // ********************
   // analog controls
   // ********************
   // sleep gates power here, so the analog side needs no mode input
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         detPower <= 1'b0;
      end else begin
         detPower <= detEn_q && !sleepMode;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pinSelect <= 1'b0;
      end else begin
         pinSelect <= (thr_q == 3'h0);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         thrLevel <= 3'h0;
      end else begin
         thrLevel <= thr_q;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bandgapOn <= 1'b0;
      end else begin
         bandgapOn <= detEn_q || lvrEnable || bgEn_q;
      end
   end

   // ********************
   // interrupt enables and flags
   // ********************
   assign vectorTake = globalEn_q && srcEn_q && grpEn_q && grpFlag_q
                       && !stackFull;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         srcEn_q <= 1'b0;
      end else if (wr && paddr == `LVDIW_OFS_IRQCTL) begin
         srcEn_q <= pwdata[`LVDIW_IRQ_SRCEN];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         grpEn_q <= 1'b0;
      end else if (wr && paddr == `LVDIW_OFS_IRQCTL) begin
         grpEn_q <= pwdata[`LVDIW_IRQ_GRPEN];
      end
   end

   // hardware clear on service, set on irq return; cpu events beat writes
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         globalEn_q <= 1'b0;
      end else if (serviceAck) begin
         globalEn_q <= 1'b0;
      end else if (retStrobe) begin
         if (lvdiw_ret_e'(retKind) == LVDIW_RET_IRQ) begin
            globalEn_q <= 1'b1;
         end
      end else if (wr && paddr == `LVDIW_OFS_IRQCTL) begin
         globalEn_q <= pwdata[`LVDIW_IRQ_GLOBAL];
      end
   end

   // source flag: set wins over software clear, kept through service
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         srcFlag_q <= 1'b0;
      end else if (delayFire) begin
         srcFlag_q <= 1'b1;
      end else if (wr && paddr == `LVDIW_OFS_IRQCTL) begin
         srcFlag_q <= pwdata[`LVDIW_IRQ_SRCFLAG];
      end
   end

   // group flag mirrors an enabled source request; service clears it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         grpFlag_q <= 1'b0;
      end else if (delayFire && srcEn_q) begin
         grpFlag_q <= 1'b1;
      end else if (serviceAck) begin
         grpFlag_q <= 1'b0;
      end else if (wr && paddr == `LVDIW_OFS_IRQCTL) begin
         grpFlag_q <= pwdata[`LVDIW_IRQ_GRPFLAG];
      end
   end

   // ********************
   // wake-up and cpu handshake
   // ********************
   assign wakeEdge = srcFlag_q && !srcFlagDly_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         srcFlagDly_q <= 1'b0;
         wakeUp       <= 1'b0;
      end else begin
         srcFlagDly_q <= srcFlag_q;
         // enables play no part here
         wakeUp <= wakeEdge && (sleepMode || idleMode);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         vectorReq <= 1'b0;
      end else begin
         vectorReq <= vectorTake && !serviceAck;
      end
   end

   // only the program counter is saved; the handler keeps the rest
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pushPc <= 1'b0;
      end else begin
         pushPc <= serviceAck;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         popPc <= 1'b0;
      end else begin
         popPc <= retStrobe;
      end
   end

   // ********************
   // event status and interrupt line
   // ********************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         status_q <= 3'h0;
      end else begin
         for (int i = 0; i < `LVDIW_ST_W; i++) begin
            if ((i == `LVDIW_ST_IRQSET && delayFire)
                || (i == `LVDIW_ST_WAKE && wakeEdge)
                || (i == `LVDIW_ST_VECTOR && serviceAck)) begin
               status_q[i] <= 1'b1;
            end else if (wr && paddr == `LVDIW_OFS_STATUS && pwdata[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mask_q <= 3'h0;
      end else if (wr && paddr == `LVDIW_OFS_MASK) begin
         mask_q <= pwdata[`LVDIW_ST_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // ********************
   // apb slave: no wait states, read data latched in setup
   // ********************
   always_comb begin
      rdMux = 32'h0000_0000;
      case (paddr)
         `LVDIW_OFS_CTRL: begin
            // upper bits stay zero
            rdMux[`LVDIW_CTRL_THR_LSB +: 3] = thr_q;
            rdMux[`LVDIW_CTRL_BGEN]         = bgEn_q;
            rdMux[`LVDIW_CTRL_EN]           = detEn_q;
            rdMux[`LVDIW_CTRL_FLAG]         = lvFlag;
         end
         `LVDIW_OFS_IRQCTL: begin
            rdMux[`LVDIW_IRQ_GLOBAL]  = globalEn_q;
            rdMux[`LVDIW_IRQ_SRCEN]   = srcEn_q;
            rdMux[`LVDIW_IRQ_GRPEN]   = grpEn_q;
            rdMux[`LVDIW_IRQ_SRCFLAG] = srcFlag_q;
            rdMux[`LVDIW_IRQ_GRPFLAG] = grpFlag_q;
         end
         `LVDIW_OFS_STATUS: rdMux[`LVDIW_ST_W-1:0] = status_q;
         `LVDIW_OFS_MASK:   rdMux[`LVDIW_ST_W-1:0] = mask_q;
         default:           rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd) begin
            prdata <= rdMux;
         end
      end
   end
endmodule : lvdiw_top
`default_nettype wire

// ---- hw/lvdiw_map.svh ----
`ifndef LVDIW_MAP_SVH
`define LVDIW_MAP_SVH

// ********************
// register byte offsets
// ********************
`define LVDIW_OFS_CTRL     12'h000
`define LVDIW_OFS_IRQCTL   12'h004
`define LVDIW_OFS_STATUS   12'h008
`define LVDIW_OFS_MASK     12'h00C
`define LVDIW_OFS_RETURN   12'h010

// ********************
// control register fields
// ********************
`define LVDIW_CTRL_THR_LSB 0
`define LVDIW_CTRL_BGEN    3
`define LVDIW_CTRL_EN      4
`define LVDIW_CTRL_FLAG    5
`define LVDIW_CTRL_RESET   6'h00

// ********************
// interrupt control fields
// ********************
`define LVDIW_IRQ_GLOBAL   0
`define LVDIW_IRQ_SRCEN    1
`define LVDIW_IRQ_GRPEN    2
`define LVDIW_IRQ_SRCFLAG  3
`define LVDIW_IRQ_GRPFLAG  4

// ********************
// status bits
// ********************
`define LVDIW_ST_IRQSET    0
`define LVDIW_ST_WAKE      1
`define LVDIW_ST_VECTOR    2
`define LVDIW_ST_W         3

// ********************
// timing
// ********************
`define LVDIW_CLK_MHZ      125
`define LVDIW_DELAY_US     45
`define LVDIW_DELAY_CYC    (`LVDIW_DELAY_US * `LVDIW_CLK_MHZ)

`endif

// ---- hw/lvdiw_pkg.sv ----
package lvdiw_pkg;
   typedef logic [2:0] lvdiw_thr_t;
   typedef enum logic {LVDIW_RET_PLAIN, LVDIW_RET_IRQ} lvdiw_ret_e;
endpackage : lvdiw_pkg

// ---- hw/lvdiw_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// three-stage input capture; a change counts once stages two and three agree
module lvdiw_sync (
   input  wire logic mclk,     // system clock
   input  wire logic resetn,   // async reset, active low
   input  wire logic asyncIn,  // raw comparator level
   output logic      syncOut   // filtered level
);
   logic [2:0] stage_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stage_q <= 3'h0;
      end else begin
         stage_q <= {stage_q[1:0], asyncIn};
      end
   end

   // stage 0 is read only by stage 1
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         syncOut <= 1'b0;
      end else if (stage_q[1] == stage_q[2]) begin
         syncOut <= stage_q[2];
      end
   end
endmodule : lvdiw_sync
`default_nettype wire

// ---- hw/lvdiw_delay.sv ----
`timescale 1ns/100ps
`default_nettype none
// counts a qualified level for DELAY cycles, then pulses once
module lvdiw_delay #(
   parameter int DELAY = 5625
) (
   input  wire logic mclk,    // system clock
   input  wire logic resetn,  // async reset, active low
   input  wire logic level,   // low-voltage level, already synchronised
   output logic      fire     // one-cycle pulse after the delay
);
   localparam int CW = $clog2(DELAY + 1);
   logic [CW-1:0] count_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_q <= '0;
         fire    <= 1'b0;
      end else if (!level) begin
         // any dip restarts the wait, so a chattering flag needs a full delay
         count_q <= '0;
         fire    <= 1'b0;
      end else if (count_q != CW'(DELAY)) begin
         count_q <= count_q + CW'(1);
         fire    <= (count_q == CW'(DELAY - 1));
      end else begin
         fire    <= 1'b0;
      end
   end
endmodule : lvdiw_delay
`default_nettype wire

// ---- verif/lvdiw_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// port checks
// ****
module lvdiw_asserts (
   input wire logic       mclk,       // clock
   input wire logic       resetn,     // reset
   input wire logic       sleepMode,  // sleep
   input wire logic       lvrEnable,  // lvr on
   input wire logic       stackFull,  // stack full
   input wire logic       serviceAck, // vector taken
   input wire logic       retStrobe,  // return
   input wire logic       detPower,   // detector power
   input wire logic       pinSelect,  // pin routed
   input wire logic [2:0] thrLevel,   // code
   input wire logic       bandgapOn,  // bandgap
   input wire logic       vectorReq,  // vector request
   input wire logic       pushPc,     // push
   input wire logic       popPc       // pop
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_sleep_kills_power:
      assert property (sleepMode |=> !detPower) else $error("power in sleep");
   a_lvr_needs_bandgap:
      assert property (lvrEnable |=> bandgapOn) else $error("bandgap off");
   a_rail_on_nonzero:
      assert property (thrLevel != 3'h0 |-> !pinSelect) else $error("pin on");
   a_stack_blocks_vector:
      assert property (stackFull |=> !vectorReq) else $error("vector full");
   a_ack_drops_request:
      assert property (serviceAck |=> !vectorReq) else $error("req stays");
   a_ack_pushes_pc:
      assert property (serviceAck |=> pushPc ##1 !pushPc) else $error("push");
   a_push_has_cause:
      assert property (pushPc |-> $past(serviceAck)) else $error("stray push");
   a_return_pops_pc:
      assert property (retStrobe |=> popPc) else $error("no pop");
endmodule : lvdiw_asserts
`default_nettype wire

// ---- verif/lvdiw_comp_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// analog comparator and reference
// ****
module lvdiw_comp_model (
   input  wire logic        power,  // detector powered
   input  wire logic        usePin, // compare external pin
   input  wire logic [2:0]  code,   // trip code
   input  wire logic [15:0] vddMv,  // supply, mV
   input  wire logic [15:0] pinMv,  // pin, mV
   output logic             lowOut  // high on low voltage
);
   int trip [8] = '{1040, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
   // no hysteresis: a slow ramp near the trip chatters as real parts do
   always_comb begin
      if (!power) lowOut = 1'b0;
      else if (usePin) lowOut = (pinMv <= trip[0]);
      else lowOut = (vddMv < trip[code]);
   end
endmodule : lvdiw_comp_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
   $display("ERROR %0t value mismatch", $time); end end
module tb_top;
   import lvdiw_pkg::*;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, compOut;
   logic sleepMode, idleMode, lvrEnable, stackFull, serviceAck, retStrobe;
   logic retKind, detPower, pinSelect, bandgapOn, vectorReq, wakeUp;
   logic pushPc, popPc, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  thrLevel;
   logic [15:0] vddMv, pinMv;
   logic [33:0] expQ [$];
   logic [33:0] e;
   logic [3:0]  ctlBits;
   int          checks, failures, cyc, wakeCnt, wakeBase;
   lvdiw_top #(.DELAY_CYC(10)) u_dut (.mclk(mclk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compOut(compOut), .sleepMode(sleepMode), .idleMode(idleMode),
      .lvrEnable(lvrEnable), .stackFull(stackFull), .serviceAck(serviceAck),
      .retStrobe(retStrobe), .retKind(retKind), .detPower(detPower),
      .pinSelect(pinSelect), .thrLevel(thrLevel), .bandgapOn(bandgapOn),
      .vectorReq(vectorReq), .wakeUp(wakeUp), .pushPc(pushPc),
      .popPc(popPc), .irq(irq));
   lvdiw_comp_model u_comp (.power(detPower), .usePin(pinSelect),
      .code(thrLevel), .vddMv(vddMv), .pinMv(pinMv), .lowOut(compOut));
   // ****
   // bus driver and result watcher
   // ****
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [33:0] x);
      expQ.push_back(x);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, {2'b00, 32'h0000_0000});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0000_0000, {2'b10, x});
   endtask : rd
   task automatic pulse(input logic ack, input logic r, input logic k);
      serviceAck <= ack; retStrobe <= r; retKind <= k;
      @(posedge mclk) serviceAck <= 1'b0;
      retStrobe <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : pulse
   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   always @(posedge mclk) begin
      if (pready === 1'b1) begin
         e = expQ.pop_front();
         `CHK(pslverr, e[32])
         if (e[33]) `CHK(prdata, e[31:0])
      end
      if (wakeUp === 1'b1) wakeCnt++;
      cyc++;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ****
   // scenarios
   // ****
   initial begin
      {resetn, psel, penable, pwrite, sleepMode, idleMode} = '0;
      {lvrEnable, stackFull, serviceAck, retStrobe, retKind} = '0;
      paddr = 12'h000; pwdata = 32'h0000_0000;
      vddMv = 16'd5000; pinMv = 16'd3000;
      void'($urandom(32'he05f));
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rd(12'h000, 32'h0000_0000);
      wr(12'h000, 32'hFFFF_FFFF);
      rd(12'h000, 32'h0000_001F);
      for (int i = 0; i < 8; i++) begin
         ctlBits = {1'($urandom), 3'(i)};
         wr(12'h000, {27'h0, 1'b1, ctlBits});
         rd(12'h000, {27'h0, 1'b1, ctlBits});
         `CHK(thrLevel, 3'(i))
         `CHK(pinSelect, i == 0)
         `CHK(detPower, 1'b1)
      end
      sleepMode <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(detPower, 1'b0)
      sleepMode <= 1'b0;
      wr(12'h000, 32'h0000_0000);
      // outputs follow the register one edge after the write lands
      @(posedge mclk);
      `CHK(bandgapOn, 1'b0)
      lvrEnable <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(bandgapOn, 1'b1)
      lvrEnable <= 1'b0;
      wr(12'h004, 32'h0000_0002);
      wr(12'h000, 32'h0000_0013);
      vddMv <= 16'd2600;
      // settle time: the capture stages need four edges before the flag
      repeat (5) @(posedge mclk);
      rd(12'h000, 32'h0000_0033);
      vddMv <= 16'd2800;
      repeat (6) @(posedge mclk);
      rd(12'h000, 32'h0000_0013);
      rd(12'h008, 32'h0000_0000);
      vddMv <= 16'd2600;
      repeat (30) @(posedge mclk);
      vddMv <= 16'd5000;
      // the wake-edge bit records any rise of the source flag
      rd(12'h008, 32'h0000_0003);
      rd(12'h004, 32'h0000_001A);
      `CHK(irq, 1'b0)
      wr(12'h00C, 32'h0000_0001);
      @(posedge mclk);
      `CHK(irq, 1'b1)
      wr(12'h008, 32'h0000_0001);
      @(posedge mclk);
      `CHK(irq, 1'b0)
      rd(12'h004, 32'h0000_001A);
      wr(12'h004, 32'h0000_001F);
      @(posedge mclk);
      `CHK(vectorReq, 1'b1)
      stackFull <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(vectorReq, 1'b0)
      stackFull <= 1'b0;
      for (int k = 1; k >= 0; k--) begin
         pulse(1'b1, 1'b0, 1'b0);
         rd(12'h004, 32'h0000_000E);
         pulse(1'b0, 1'b1, k[0]);
         rd(12'h004, {31'h0000_0007, k[0]});
      end
      for (int p = 1; p >= 0; p--) begin
         wr(12'h004, {28'h0, p[0], 3'h0});
         wakeBase = wakeCnt;
         idleMode <= 1'b1;
         vddMv <= 16'd2600;
         repeat (30) @(posedge mclk);
         vddMv <= 16'd5000;
         idleMode <= 1'b0;
         `CHK(wakeCnt != wakeBase, !p[0])
      end
      rd(12'h008, 32'h0000_0007);
      xfer(1'b0, 12'h020, 32'h0000_0000, {2'b11, 32'h0000_0000});
      rd(12'h010, 32'h0000_0000);
      repeat (4) @(posedge mclk);
      results();
   end
endmodule : tb_top
bind lvdiw_top lvdiw_asserts u_chk (.mclk(mclk), .resetn(resetn),
   .sleepMode(sleepMode), .lvrEnable(lvrEnable), .stackFull(stackFull),
   .serviceAck(serviceAck), .retStrobe(retStrobe), .detPower(detPower),
   .pinSelect(pinSelect), .thrLevel(thrLevel), .bandgapOn(bandgapOn),
   .vectorReq(vectorReq), .pushPc(pushPc), .popPc(popPc));
`default_nettype wire
